// ===== common/spi_port_pkg.sv
// constants and types shared by the spi port and its transmit fifo
package spi_port_pkg;
  localparam int WORD_BITS = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int BAUD_BITS = 8;
  localparam int CNT_BITS = 4;
  localparam int SYNC_STAGES = 3;
  localparam logic [CNT_BITS-1:0] LAST_BIT = 4'hF;
  localparam logic [CNT_BITS-1:0] CNT_RESET = 4'h0;
  localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
  localparam logic [BAUD_BITS-1:0] DIV_RESET = 8'h00;
  localparam logic [SYNC_STAGES-1:0] SYNC_RESET = 3'h0;
  localparam logic [1:0] LINK_RST_RESET = 2'h3;
  typedef logic [WORD_BITS-1:0] word_t;
  typedef enum logic [1:0]
  {
    M_IDLE = 2'b00,
    M_LOW = 2'b01,
    M_HIGH = 2'b10
  } master_state_e;
endpackage

// ===== common/fifo_if.sv
// stream interface between the port logic and its transmit fifo
interface fifo_if #(parameter int WIDTH = spi_port_pkg::WORD_BITS);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  logic flush;
  logic limit_one;
  modport store
  (
    input in_valid, in_data, out_ready, flush, limit_one,
    output in_ready, out_valid, out_data
  );
  modport user
  (
    output in_valid, in_data, out_ready, flush, limit_one,
    input in_ready, out_valid, out_data
  );
endinterface

// ===== rtl/spi_fifo.sv
// transmit fifo with a registered head word and registered ready
module spi_fifo #(
  parameter int WIDTH = spi_port_pkg::WORD_BITS,
  parameter int DEPTH = spi_port_pkg::FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_srst,
  fifo_if.store port
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] CAP_ONE = (PW+1)'(1);
  localparam logic [PW:0] CAP_FULL = (PW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [PW:0] cnt_reg, cnt_next;
  logic head_valid_reg, head_valid_next;
  logic [WIDTH-1:0] head_reg, head_next;
  logic ready_reg, ready_next;
  logic wr, take, mem_wr;
  logic [PW:0] total;

  assign port.in_ready = ready_reg;
  assign port.out_valid = head_valid_reg;
  assign port.out_data = head_reg;

  always_comb
  begin
    wr = port.in_valid & ready_reg;
    take = ~head_valid_reg | port.out_ready;
    mem_wr = 1'b0;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    head_valid_next = head_valid_reg;
    head_next = head_reg;
    if (take)
    begin
      if (cnt_reg != '0)
      begin
        head_next = mem[rd_reg];
        head_valid_next = 1'b1;
        rd_next = PW'(rd_reg + 1'b1);
        cnt_next = (PW+1)'(cnt_reg - 1'b1);
        mem_wr = wr;
      end
      else
      begin
        head_next = port.in_data;
        head_valid_next = wr;
      end
    end
    else
    begin
      mem_wr = wr;
    end
    if (mem_wr)
    begin
      wr_next = PW'(wr_reg + 1'b1);
      cnt_next = (PW+1)'(cnt_next + 1'b1);
    end
    if (port.flush)
    begin
      wr_next = '0;
      rd_next = '0;
      cnt_next = '0;
      head_valid_next = 1'b0;
    end
    total = (PW+1)'(cnt_next + head_valid_next);
    // ready is a flop, so it looks one word ahead of the write it allows
    ready_next = (total + (PW+1)'(wr)) < (port.limit_one ? CAP_ONE : CAP_FULL);
    if (port.flush)
    begin
      ready_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (mem_wr)
    begin
      mem[wr_reg] <= port.in_data;
    end
    if (i_srst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      head_valid_reg <= 1'b0;
      head_reg <= '0;
      ready_reg <= 1'b0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      head_valid_reg <= head_valid_next;
      head_reg <= head_next;
      ready_reg <= ready_next;
    end
  end
endmodule // spi_fifo

// ===== rtl/spi_master_slave_port.sv
// spi port acting as bus master or bus slave, with a transmit fifo
module spi_master_slave_port (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_link_sck,
  input wire logic i_port_enable,
  input wire logic i_enhanced_buffer_select,
  input wire logic i_master_select,
  input wire logic i_slave_select_enable,
  input wire logic [spi_port_pkg::BAUD_BITS-1:0] i_baud_div,
  input wire logic [spi_port_pkg::WORD_BITS-1:0] i_tx_data,
  input wire logic i_tx_write,
  output logic o_tx_ready,
  output logic o_tx_buffer_empty_flag,
  output logic [spi_port_pkg::WORD_BITS-1:0] o_rx_data,
  output logic o_rx_valid,
  input wire logic i_rx_read,
  output logic o_receive_overflow_flag,
  input wire logic i_overflow_clear,
  output logic o_busy,
  input wire logic i_serial_data_in,
  input wire logic i_slave_select_in_n,
  output logic o_serial_data_out,
  output logic o_serial_data_out_en,
  output logic o_link_sck,
  output logic o_link_sck_en
);
  function automatic logic bit_of(input spi_port_pkg::word_t w,
                                  input logic [spi_port_pkg::CNT_BITS-1:0] idx);
    bit_of = w[idx];
  endfunction

  fifo_if #(.WIDTH(spi_port_pkg::WORD_BITS)) txq ();
  spi_fifo #(
    .WIDTH(spi_port_pkg::WORD_BITS),
    .DEPTH(spi_port_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .port(txq.store)
  );

  // system clock domain state
  logic [spi_port_pkg::SYNC_STAGES-1:0] sdi_sync_reg, sdi_sync_next;
  logic [spi_port_pkg::SYNC_STAGES-1:0] ss_sync_reg, ss_sync_next;
  logic [spi_port_pkg::SYNC_STAGES-1:0] done_sync_reg, done_sync_next;
  logic ss_high_reg, ss_high_next;
  logic done_seen_reg, done_seen_next;
  spi_port_pkg::master_state_e m_state_reg, m_state_next;
  logic [spi_port_pkg::BAUD_BITS-1:0] div_reg, div_next;
  logic [spi_port_pkg::CNT_BITS-1:0] bit_cnt_reg, bit_cnt_next;
  spi_port_pkg::word_t tx_shift_register, tx_shift_next;
  spi_port_pkg::word_t rx_shift_reg, rx_shift_next;
  spi_port_pkg::word_t rx_data_reg, rx_data_next;
  logic rx_valid_reg, rx_valid_next;
  logic ovf_reg, ovf_next;
  logic tbe_reg, tbe_next;
  logic sck_reg, sck_next;
  logic sdo_reg, sdo_next;
  logic oe_reg, oe_next;
  logic sck_en_reg, sck_en_next;
  logic busy_reg, busy_next;
  logic slave_loaded_reg, slave_loaded_next;
  logic restart_cond_reg, restart_cond_next;
  logic restart_tgl_reg, restart_tgl_next;
  logic done_evt, capture, pop, master_on, slave_on;
  spi_port_pkg::word_t capture_word;

  // link clock domain state
  logic [1:0] lk_rst_reg, lk_rst_next;
  logic [spi_port_pkg::CNT_BITS-1:0] lk_cnt_reg, lk_cnt_next;
  spi_port_pkg::word_t lk_rx_reg, lk_rx_next;
  spi_port_pkg::word_t lk_word_reg, lk_word_next;
  logic lk_done_tgl_reg, lk_done_tgl_next;
  logic lk_seen_reg, lk_seen_next;
  logic lk_sdo_reg, lk_sdo_next;
  logic lk_restart, lk_active, slave_sdo;
  logic [spi_port_pkg::CNT_BITS-1:0] lk_cnt_eff;

  assign master_on = i_port_enable & i_master_select;
  assign slave_on = i_port_enable & ~i_master_select;

  assign txq.in_valid = i_tx_write;
  assign txq.in_data = i_tx_data;
  assign txq.out_ready = pop;
  assign txq.flush = ~i_port_enable;
  assign txq.limit_one = ~i_enhanced_buffer_select;

  always_comb
  begin
    sdi_sync_next = {sdi_sync_reg[1:0], i_serial_data_in};
    ss_sync_next = {ss_sync_reg[1:0], i_slave_select_in_n};
    done_sync_next = {done_sync_reg[1:0], lk_done_tgl_reg};
    ss_high_next = (ss_sync_reg[1] == ss_sync_reg[2]) ? ss_sync_reg[2] : ss_high_reg;
    done_evt = (done_sync_reg[1] == done_sync_reg[2]) & (done_sync_reg[2] != done_seen_reg);
    done_seen_next = done_evt ? done_sync_reg[2] : done_seen_reg;
    m_state_next = m_state_reg;
    div_next = div_reg;
    bit_cnt_next = bit_cnt_reg;
    tx_shift_next = tx_shift_register;
    rx_shift_next = rx_shift_reg;
    sck_next = sck_reg;
    sdo_next = sdo_reg;
    slave_loaded_next = slave_loaded_reg & slave_on;
    pop = 1'b0;
    capture = 1'b0;
    capture_word = lk_word_reg;
    case (m_state_reg)
      spi_port_pkg::M_IDLE:
      begin
        sck_next = 1'b0;
        if (master_on & txq.out_valid)
        begin
          tx_shift_next = txq.out_data;
          pop = 1'b1;
          sdo_next = txq.out_data[spi_port_pkg::WORD_BITS-1];
          bit_cnt_next = spi_port_pkg::CNT_RESET;
          div_next = spi_port_pkg::DIV_RESET;
          m_state_next = spi_port_pkg::M_LOW;
        end
      end
      spi_port_pkg::M_LOW:
      begin
        div_next = spi_port_pkg::BAUD_BITS'(div_reg + 1'b1);
        if (div_reg == i_baud_div)
        begin
          div_next = spi_port_pkg::DIV_RESET;
          sck_next = 1'b1;
          rx_shift_next = {rx_shift_reg[spi_port_pkg::WORD_BITS-2:0], sdi_sync_reg[2]};
          m_state_next = spi_port_pkg::M_HIGH;
        end
      end
      spi_port_pkg::M_HIGH:
      begin
        div_next = spi_port_pkg::BAUD_BITS'(div_reg + 1'b1);
        if (div_reg == i_baud_div)
        begin
          div_next = spi_port_pkg::DIV_RESET;
          sck_next = 1'b0;
          if (bit_cnt_reg == spi_port_pkg::LAST_BIT)
          begin
            capture = 1'b1;
            capture_word = rx_shift_reg;
            m_state_next = spi_port_pkg::M_IDLE;
          end
          else
          begin
            bit_cnt_next = spi_port_pkg::CNT_BITS'(bit_cnt_reg + 1'b1);
            tx_shift_next = {tx_shift_register[spi_port_pkg::WORD_BITS-2:0], 1'b0};
            sdo_next = tx_shift_register[spi_port_pkg::WORD_BITS-2];
            m_state_next = spi_port_pkg::M_LOW;
          end
        end
      end
      default:
      begin
        m_state_next = spi_port_pkg::M_IDLE;
      end
    endcase
    if (slave_on)
    begin
      // the word stays put while loaded, so the link side may read it directly
      if (~slave_loaded_reg & txq.out_valid)
      begin
        tx_shift_next = txq.out_data;
        slave_loaded_next = 1'b1;
        pop = ~i_slave_select_enable;
      end
      if (done_evt)
      begin
        capture = 1'b1;
        slave_loaded_next = 1'b0;
        pop = i_slave_select_enable & txq.out_valid;
      end
    end
    rx_data_next = rx_data_reg;
    rx_valid_next = rx_valid_reg & ~i_rx_read;
    ovf_next = ovf_reg & ~i_overflow_clear;
    if (capture)
    begin
      rx_data_next = capture_word;
      rx_valid_next = 1'b1;
      ovf_next = ovf_next | (rx_valid_reg & ~i_rx_read);
    end
    // head of the fifo is the holding buffer; a write clears empty two cycles later
    tbe_next = ~txq.out_valid;
    oe_next = master_on | (slave_on & ~(i_slave_select_enable & ss_high_reg));
    sck_en_next = master_on;
    busy_next = (m_state_next != spi_port_pkg::M_IDLE) | slave_loaded_next;
    restart_cond_next = ~slave_on | (i_slave_select_enable & ss_high_reg);
    restart_tgl_next = restart_tgl_reg ^ (restart_cond_next & ~restart_cond_reg);
    if (~i_port_enable)
    begin
      m_state_next = spi_port_pkg::M_IDLE;
      sck_next = 1'b0;
      sdo_next = 1'b0;
      rx_valid_next = 1'b0;
      ovf_next = 1'b0;
      tx_shift_next = spi_port_pkg::WORD_RESET;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      sdi_sync_reg <= spi_port_pkg::SYNC_RESET;
      ss_sync_reg <= spi_port_pkg::SYNC_RESET;
      done_sync_reg <= spi_port_pkg::SYNC_RESET;
      ss_high_reg <= 1'b0;
      done_seen_reg <= 1'b0;
      m_state_reg <= spi_port_pkg::M_IDLE;
      div_reg <= spi_port_pkg::DIV_RESET;
      bit_cnt_reg <= spi_port_pkg::CNT_RESET;
      tx_shift_register <= spi_port_pkg::WORD_RESET;
      rx_shift_reg <= spi_port_pkg::WORD_RESET;
      rx_data_reg <= spi_port_pkg::WORD_RESET;
      rx_valid_reg <= 1'b0;
      ovf_reg <= 1'b0;
      tbe_reg <= 1'b1;
      sck_reg <= 1'b0;
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
      sck_en_reg <= 1'b0;
      busy_reg <= 1'b0;
      slave_loaded_reg <= 1'b0;
      restart_cond_reg <= 1'b1;
      restart_tgl_reg <= 1'b0;
    end
    else
    begin
      sdi_sync_reg <= sdi_sync_next;
      ss_sync_reg <= ss_sync_next;
      done_sync_reg <= done_sync_next;
      ss_high_reg <= ss_high_next;
      done_seen_reg <= done_seen_next;
      m_state_reg <= m_state_next;
      div_reg <= div_next;
      bit_cnt_reg <= bit_cnt_next;
      tx_shift_register <= tx_shift_next;
      rx_shift_reg <= rx_shift_next;
      rx_data_reg <= rx_data_next;
      rx_valid_reg <= rx_valid_next;
      ovf_reg <= ovf_next;
      tbe_reg <= tbe_next;
      sck_reg <= sck_next;
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
      sck_en_reg <= sck_en_next;
      busy_reg <= busy_next;
      slave_loaded_reg <= slave_loaded_next;
      restart_cond_reg <= restart_cond_next;
      restart_tgl_reg <= restart_tgl_next;
    end
  end

  // link side: restart toggle, shift word and config are quasi-static,
  // they only change while the master clock is idle between frames
  always_comb
  begin
    lk_rst_next = {lk_rst_reg[0], i_srst};
    lk_restart = lk_seen_reg != restart_tgl_reg;
    lk_active = slave_on & ~(i_slave_select_enable & i_slave_select_in_n);
    lk_cnt_eff = lk_restart ? spi_port_pkg::CNT_RESET : lk_cnt_reg;
    lk_cnt_next = lk_cnt_reg;
    lk_rx_next = lk_rx_reg;
    lk_word_next = lk_word_reg;
    lk_done_tgl_next = lk_done_tgl_reg;
    lk_seen_next = lk_seen_reg;
    if (lk_active)
    begin
      lk_seen_next = restart_tgl_reg;
      lk_rx_next = {lk_restart ? spi_port_pkg::WORD_RESET[spi_port_pkg::WORD_BITS-2:0]
                               : lk_rx_reg[spi_port_pkg::WORD_BITS-2:0], i_serial_data_in};
      lk_cnt_next = spi_port_pkg::CNT_BITS'(lk_cnt_eff + 1'b1);
      if (lk_cnt_eff == spi_port_pkg::LAST_BIT)
      begin
        lk_word_next = lk_rx_next;
        lk_done_tgl_next = ~lk_done_tgl_reg;
        lk_cnt_next = spi_port_pkg::CNT_RESET;
      end
    end
    lk_sdo_next = bit_of(tx_shift_register, spi_port_pkg::LAST_BIT - lk_cnt_reg);
    slave_sdo = ((lk_cnt_reg == spi_port_pkg::CNT_RESET) | lk_restart)
              ? tx_shift_register[spi_port_pkg::WORD_BITS-1] : lk_sdo_reg;
  end

  always_ff @(posedge i_link_sck)
  begin
    lk_rst_reg <= lk_rst_next;
    if (lk_rst_reg[1])
    begin
      lk_cnt_reg <= spi_port_pkg::CNT_RESET;
      lk_rx_reg <= spi_port_pkg::WORD_RESET;
      lk_word_reg <= spi_port_pkg::WORD_RESET;
      lk_done_tgl_reg <= 1'b0;
      lk_seen_reg <= 1'b0;
    end
    else
    begin
      lk_cnt_reg <= lk_cnt_next;
      lk_rx_reg <= lk_rx_next;
      lk_word_reg <= lk_word_next;
      lk_done_tgl_reg <= lk_done_tgl_next;
      lk_seen_reg <= lk_seen_next;
    end
  end

  // data out changes on the falling edge, the master samples on the rising one
  always_ff @(negedge i_link_sck) lk_sdo_reg <= lk_sdo_next;

  assign o_tx_ready = txq.in_ready;
  assign o_tx_buffer_empty_flag = tbe_reg;
  assign o_rx_data = rx_data_reg;
  assign o_rx_valid = rx_valid_reg;
  assign o_receive_overflow_flag = ovf_reg;
  assign o_busy = busy_reg;
  assign o_serial_data_out = sck_en_reg ? sdo_reg : slave_sdo;
  assign o_serial_data_out_en = oe_reg;
  assign o_link_sck = sck_reg;
  assign o_link_sck_en = sck_en_reg;
endmodule // spi_master_slave_port

// ===== dv/spi_port_props.sv
// concurrent checks on the spi port top-level pins
module spi_port_props (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_port_enable,
  input wire logic i_enhanced_buffer_select,
  input wire logic i_master_select,
  input wire logic i_slave_select_enable,
  input wire logic [spi_port_pkg::BAUD_BITS-1:0] i_baud_div,
  input wire logic i_tx_write,
  input wire logic o_tx_ready,
  input wire logic o_tx_buffer_empty_flag,
  input wire logic o_receive_overflow_flag,
  input wire logic o_busy,
  input wire logic i_slave_select_in_n,
  input wire logic o_serial_data_out_en,
  input wire logic o_link_sck,
  input wire logic o_link_sck_en
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  disable_clears_a: assert property (!i_port_enable [*3] |-> o_tx_buffer_empty_flag
    && !o_busy && !o_receive_overflow_flag) else $error("disable left state behind");
  master_clock_drive_a: assert property ((i_port_enable && i_master_select) [*2]
    |-> o_link_sck_en) else $error("master does not drive its clock");
  slave_clock_off_a: assert property (!i_master_select [*2] |-> !o_link_sck_en)
    else $error("slave drives the clock pin");
  master_start_a: assert property (i_tx_write && o_tx_ready && i_port_enable
    && i_master_select && !o_busy |-> ##[1:4] o_busy) else $error("master did not start");
  half_period_a: assert property (i_baud_div == 8'h03 && o_busy && $changed(o_link_sck)
    |=> $stable(o_link_sck) [*3]) else $error("serial clock half period short");
  single_buffer_a: assert property (i_tx_write && o_tx_ready && i_port_enable
    && !i_enhanced_buffer_select |=> !o_tx_ready) else $error("single buffer took more");
  load_clears_empty_a: assert property (i_tx_write && o_tx_ready && i_port_enable
    |-> ##[1:3] !o_tx_buffer_empty_flag) else $error("empty flag did not clear");
  deselect_release_a: assert property ((!i_master_select && i_slave_select_enable
    && i_slave_select_in_n) [*6] |-> !o_serial_data_out_en) else $error("data pin still driven");
  held_word_a: assert property ((!i_master_select && i_slave_select_enable
    && i_slave_select_in_n && i_port_enable) [*8] ##0 !o_tx_buffer_empty_flag
    |=> !o_tx_buffer_empty_flag) else $error("empty set while deselected");
endmodule // spi_port_props

bind spi_master_slave_port spi_port_props chk (
  .i_clk(i_clk),
  .i_srst(i_srst),
  .i_port_enable(i_port_enable),
  .i_enhanced_buffer_select(i_enhanced_buffer_select),
  .i_master_select(i_master_select),
  .i_slave_select_enable(i_slave_select_enable),
  .i_baud_div(i_baud_div),
  .i_tx_write(i_tx_write),
  .o_tx_ready(o_tx_ready),
  .o_tx_buffer_empty_flag(o_tx_buffer_empty_flag),
  .o_receive_overflow_flag(o_receive_overflow_flag),
  .o_busy(o_busy),
  .i_slave_select_in_n(i_slave_select_in_n),
  .o_serial_data_out_en(o_serial_data_out_en),
  .o_link_sck(o_link_sck),
  .o_link_sck_en(o_link_sck_en)
);

// ===== dv/spi_far_end.sv
// far end of the link: a slave when the port masters, a master otherwise
module spi_far_end (
  input wire logic i_master_sck,
  input wire logic i_sdo,
  input wire logic i_sdo_en,
  output logic o_sck,
  output logic o_ss_n,
  output logic o_sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  spi_port_pkg::word_t reply = 16'h0000;
  spi_port_pkg::word_t got = 16'h0000;
  initial
  begin
    o_sck = 1'b0;
    o_ss_n = 1'b1;
    o_sdi = 1'b0;
  end
  // an undriven data pin reads as unknown so a retry on a released pin shows
  always @(posedge i_master_sck) got = {got[14:0], i_sdo_en ? i_sdo : 1'bx};
  // reply rotates, so every frame answers with the same word
  always @(negedge i_master_sck)
  begin
    reply = {reply[14:0], reply[15]};
    o_sdi = reply[15];
  end
  task automatic arm(input spi_port_pkg::word_t w);
    reply = w;
    o_sdi = w[15];
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      #7.5 o_sck = 1'b1;
      #7.5 o_sck = 1'b0;
    end
  endtask
  // clock runs only inside a frame; the port's bit is taken just before the rise
  task automatic frame(input spi_port_pkg::word_t w, input int n, input logic sel);
    o_ss_n = !sel;
    o_sdi = w[15];
    #30;
    repeat (n)
    begin
      #7.5 got = {got[14:0], i_sdo_en ? i_sdo : 1'bx};
      o_sck = 1'b1;
      #7.5 o_sck = 1'b0;
      w = w << 1;
      o_sdi = w[15];
    end
    #30 o_ss_n = 1'b1;
    o_sdi = ~o_sdi;
  endtask
endmodule // spi_far_end

// ===== dv/tb.sv
// self-checking bench for the spi port in master and slave roles
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_port_enable = 1'b0;
  logic i_enhanced_buffer_select = 1'b0;
  logic i_master_select = 1'b0;
  logic i_slave_select_enable = 1'b0;
  logic [7:0] i_baud_div = 8'h03;
  spi_port_pkg::word_t i_tx_data = 16'h0000;
  logic i_tx_write = 1'b0;
  logic i_rx_read = 1'b0;
  logic i_overflow_clear = 1'b0;
  logic o_tx_ready, o_tx_buffer_empty_flag, o_rx_valid, o_receive_overflow_flag, o_busy;
  logic o_serial_data_out, o_serial_data_out_en, o_link_sck, o_link_sck_en;
  logic link_sck, ss_n, sdi;
  spi_port_pkg::word_t o_rx_data;
  spi_port_pkg::word_t words [3] = '{16'h8001, 16'h7FFE, 16'hC3C3};
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  always #2.5 i_clk = ~i_clk;
  spi_master_slave_port dut (.i_clk(i_clk), .i_srst(i_srst), .i_link_sck(link_sck),
    .i_port_enable(i_port_enable), .i_enhanced_buffer_select(i_enhanced_buffer_select),
    .i_master_select(i_master_select), .i_slave_select_enable(i_slave_select_enable),
    .i_baud_div(i_baud_div), .i_tx_data(i_tx_data), .i_tx_write(i_tx_write),
    .o_tx_ready(o_tx_ready), .o_tx_buffer_empty_flag(o_tx_buffer_empty_flag),
    .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .i_rx_read(i_rx_read),
    .o_receive_overflow_flag(o_receive_overflow_flag), .i_overflow_clear(i_overflow_clear),
    .o_busy(o_busy), .i_serial_data_in(sdi), .i_slave_select_in_n(ss_n),
    .o_serial_data_out(o_serial_data_out), .o_serial_data_out_en(o_serial_data_out_en),
    .o_link_sck(o_link_sck), .o_link_sck_en(o_link_sck_en));
  spi_far_end far (.i_master_sck(o_link_sck), .i_sdo(o_serial_data_out),
    .i_sdo_en(o_serial_data_out_en), .o_sck(link_sck), .o_ss_n(ss_n), .o_sdi(sdi));

  task automatic complete_run;
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_word(input spi_port_pkg::word_t got, input spi_port_pkg::word_t exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask
  // a write is taken at the second rising edge after ready was seen high
  task automatic write_word(input spi_port_pkg::word_t w);
    int n;
    n = 0;
    @(negedge i_clk);
    while (o_tx_ready !== 1'b1 && n < 400)
    begin
      @(negedge i_clk);
      n++;
    end
    @(posedge i_clk);
    i_tx_write <= 1'b1;
    i_tx_data <= w;
    @(posedge i_clk);
    i_tx_write <= 1'b0;
  endtask
  task automatic read_word(input spi_port_pkg::word_t exp);
    int n;
    n = 0;
    @(negedge i_clk);
    while (o_rx_valid !== 1'b1 && n < 1000)
    begin
      @(negedge i_clk);
      n++;
    end
    chk_word(o_rx_data, exp);
    @(posedge i_clk);
    i_rx_read <= 1'b1;
    @(posedge i_clk);
    i_rx_read <= 1'b0;
  endtask
  task automatic setup(input logic mst, input logic enh, input logic slave_select_enable);
    @(posedge i_clk);
    i_port_enable <= 1'b0;
    i_rx_read <= 1'b1;
    i_overflow_clear <= 1'b1;
    @(posedge i_clk);
    i_rx_read <= 1'b0;
    i_overflow_clear <= 1'b0;
    i_enhanced_buffer_select <= enh;
    i_master_select <= mst;
    i_slave_select_enable <= slave_select_enable;
    @(posedge i_clk);
    i_port_enable <= 1'b1;
    repeat (2) @(posedge i_clk);
  endtask

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end

  initial
  begin
    // the link side resets only on its own clock edges
    fork
      far.tick(4);
      repeat (20) @(posedge i_clk);
    join
    i_srst <= 1'b0;
    // the link reset synchroniser needs two more link edges to let go
    far.tick(3);
    @(negedge i_clk);
    chk_flag(o_tx_buffer_empty_flag, 1'b1);
    setup(1'b1, 1'b0, 1'b0);
    far.arm(16'hA5C3);
    write_word(16'h3C5A);
    read_word(16'hA5C3);
    chk_word(far.got, 16'h3C5A);
    chk_flag(o_tx_buffer_empty_flag, 1'b1);
    setup(1'b1, 1'b1, 1'b0);
    foreach (words[i]) write_word(words[i]);
    @(negedge i_clk);
    chk_flag(o_tx_buffer_empty_flag, 1'b0);
    foreach (words[i])
    begin
      read_word(16'hA5C3);
      chk_word(far.got, words[i]);
    end
    // two words with no read between them must raise overflow
    write_word(16'h0001);
    write_word(16'h0002);
    repeat (300) @(negedge i_clk);
    chk_flag(o_receive_overflow_flag, 1'b1);
    setup(1'b0, 1'b1, 1'b0);
    chk_flag(o_receive_overflow_flag, 1'b0);
    write_word(16'h1111);
    write_word(16'h2222);
    @(posedge i_clk);
    i_port_enable <= 1'b0;
    repeat (4) @(negedge i_clk);
    chk_flag(o_tx_buffer_empty_flag, 1'b1);
    chk_flag(o_busy, 1'b0);
    setup(1'b0, 1'b0, 1'b0);
    write_word(16'h96E1);
    repeat (4) @(posedge i_clk);
    far.frame(16'h5A0F, 16, 1'b0);
    read_word(16'h5A0F);
    chk_word(far.got, 16'h96E1);
    chk_flag(o_tx_buffer_empty_flag, 1'b1);
    setup(1'b0, 1'b0, 1'b1);
    write_word(16'hC3A5);
    repeat (4) @(posedge i_clk);
    far.frame(16'h1234, 16, 1'b0);
    repeat (8) @(negedge i_clk);
    chk_flag(o_rx_valid, 1'b0);
    far.frame(16'h1234, 5, 1'b1);
    repeat (8) @(negedge i_clk);
    chk_flag(o_serial_data_out_en, 1'b0);
    chk_flag(o_tx_buffer_empty_flag, 1'b0);
    far.frame(16'h0F5A, 16, 1'b1);
    read_word(16'h0F5A);
    chk_word(far.got, 16'hC3A5);
    chk_flag(o_tx_buffer_empty_flag, 1'b1);
    complete_run();
  end
endmodule // tb
